//--- logic/clk_irq_ctrl.sv
// clock event interrupt register: w1c clears, flags, enables, request
// assumes event inputs are synchronous one-cycle or level detect pulses
`timescale 1ns/100ps
module clk_irq_ctrl
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// register port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// events from oscillators and monitors
	input wire logic fast_crystal_stuck,
	input wire logic pll_stuck,
	input wire logic slow_crystal_stuck,
	input wire logic pll_stable,
	input wire logic fast_crystal_stable,
	input wire logic rc8mhz_stable,
	input wire logic slow_crystal_stable,
	input wire logic rc40khz_stable,
	// enables outside this block's bit range
	input wire logic rc8mhz_stable_irq_enable,
	input wire logic slow_crystal_stable_irq_enable,
	input wire logic rc40khz_stable_irq_enable,
	input wire logic fast_crystal_monitor_nmi_enable,
	// state out
	output logic [7:0] flags,
	output logic irq
);
	logic [7:0] flag_w;
	logic [7:0] set_w;
	logic [7:0] clr_w;
	logic [7:0] ev_w;
	logic [7:0] en_all;
	logic [3:0] en_q;
	logic [3:0] en_d;
	logic nmi_en_q;
	logic sel;
	logic wr_hit;
	logic [31:0] rd_word;
	logic irq_d;
	// software enables by name, bits 14:11
	logic pll_monitor_irq_enable;
	logic slow_crystal_monitor_irq_enable;
	logic pll_stable_irq_enable;
	logic fast_crystal_stable_irq_enable;
	// write-one-to-clear strobes by name, bits 23:16
	logic fast_crystal_stuck_clear;
	logic pll_monitor_clear;
	logic slow_crystal_monitor_clear;
	logic pll_stable_clear;
	logic fast_crystal_stable_clear;
	logic rc8mhz_stable_clear;
	logic slow_crystal_stable_clear;
	logic rc40khz_stable_clear;
	// rising edge of the nmi enable level
	logic nmi_rise;
	// sticky flags by name, bits 7:0
	logic fast_crystal_stuck_flag;
	logic pll_monitor_flag;
	logic slow_crystal_monitor_flag;
	logic pll_stable_flag;
	logic fast_crystal_stable_flag;
	logic rc8mhz_stable_flag;
	logic slow_crystal_stable_flag;
	logic rc40khz_stable_flag;
	// read word fields
	logic [7:0] rd_resv_hi;
	logic [7:0] rd_clear_bits;
	logic rd_resv_15;
	logic [2:0] rd_ext_en;

	// one clear strobe per bit; zeros written leave the flag alone
	function automatic logic w1c_hit(input logic hit,
		input logic [31:0] d, input int pos);
		w1c_hit = hit & d[clk_irq_pkg::CLR_BASE + pos];
	endfunction : w1c_hit

	// event gated by its enable; ungated events pass a constant 1
	function automatic logic gate_set(input logic ev, input logic en);
		gate_set = ev & en;
	endfunction : gate_set

	assign sel = (addr == clk_irq_pkg::REG_ADDR);
	assign wr_hit = wr & sel;

	// bits 31:24 and 15 are not stored; writes there are dropped
	assign en_d = wr_hit ? wdata[clk_irq_pkg::EN_HI_WRITABLE:
		clk_irq_pkg::EN_LO_WRITABLE] : en_q;

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			en_q <= clk_irq_pkg::EN_RESET[6:3];
			nmi_en_q <= 1'b0;
		end
		else
		begin
			en_q <= en_d;
			nmi_en_q <= fast_crystal_monitor_nmi_enable;
		end
	end

	// stored enables by name, in register order
	assign pll_monitor_irq_enable = en_q[3];
	assign slow_crystal_monitor_irq_enable = en_q[2];
	assign pll_stable_irq_enable = en_q[1];
	assign fast_crystal_stable_irq_enable = en_q[0];

	// enable per flag; stuck flag 7 has no own enable here
	assign en_all = {1'b1,
		pll_monitor_irq_enable,
		slow_crystal_monitor_irq_enable,
		pll_stable_irq_enable,
		fast_crystal_stable_irq_enable,
		rc8mhz_stable_irq_enable,
		slow_crystal_stable_irq_enable,
		rc40khz_stable_irq_enable};

	assign ev_w = {fast_crystal_stuck, pll_stuck, slow_crystal_stuck,
		pll_stable, fast_crystal_stable, rc8mhz_stable,
		slow_crystal_stable, rc40khz_stable};

	// monitor flags set on any stuck event, enable only masks irq
	assign set_w[clk_irq_pkg::F_FAST_STUCK] =
		gate_set(ev_w[clk_irq_pkg::F_FAST_STUCK], 1'b1);
	assign set_w[clk_irq_pkg::F_PLL_MON] =
		gate_set(ev_w[clk_irq_pkg::F_PLL_MON], 1'b1);
	assign set_w[clk_irq_pkg::F_SLOW_MON] =
		gate_set(ev_w[clk_irq_pkg::F_SLOW_MON], 1'b1);
	// stable flags only set while their enable is on
	assign set_w[clk_irq_pkg::F_PLL_STB] =
		gate_set(ev_w[clk_irq_pkg::F_PLL_STB],
		pll_stable_irq_enable);
	assign set_w[clk_irq_pkg::F_FAST_STB] =
		gate_set(ev_w[clk_irq_pkg::F_FAST_STB],
		fast_crystal_stable_irq_enable);
	assign set_w[clk_irq_pkg::F_RC8M] =
		gate_set(ev_w[clk_irq_pkg::F_RC8M], rc8mhz_stable_irq_enable);
	assign set_w[clk_irq_pkg::F_SLOW_STB] =
		gate_set(ev_w[clk_irq_pkg::F_SLOW_STB],
		slow_crystal_stable_irq_enable);
	assign set_w[clk_irq_pkg::F_RC40K] =
		gate_set(ev_w[clk_irq_pkg::F_RC40K], rc40khz_stable_irq_enable);

	// write-one-to-clear strobes
	assign fast_crystal_stuck_clear =
		w1c_hit(wr_hit, wdata, clk_irq_pkg::F_FAST_STUCK);
	assign pll_monitor_clear =
		w1c_hit(wr_hit, wdata, clk_irq_pkg::F_PLL_MON);
	assign slow_crystal_monitor_clear =
		w1c_hit(wr_hit, wdata, clk_irq_pkg::F_SLOW_MON);
	assign pll_stable_clear =
		w1c_hit(wr_hit, wdata, clk_irq_pkg::F_PLL_STB);
	assign fast_crystal_stable_clear =
		w1c_hit(wr_hit, wdata, clk_irq_pkg::F_FAST_STB);
	assign rc8mhz_stable_clear =
		w1c_hit(wr_hit, wdata, clk_irq_pkg::F_RC8M);
	assign slow_crystal_stable_clear =
		w1c_hit(wr_hit, wdata, clk_irq_pkg::F_SLOW_STB);
	assign rc40khz_stable_clear =
		w1c_hit(wr_hit, wdata, clk_irq_pkg::F_RC40K);

	// only the edge clears; a held nmi enable lets the flag set again
	assign nmi_rise = fast_crystal_monitor_nmi_enable & ~nmi_en_q;

	assign clr_w[clk_irq_pkg::F_FAST_STUCK] =
		fast_crystal_stuck_clear | nmi_rise;
	assign clr_w[clk_irq_pkg::F_PLL_MON] = pll_monitor_clear;
	assign clr_w[clk_irq_pkg::F_SLOW_MON] = slow_crystal_monitor_clear;
	assign clr_w[clk_irq_pkg::F_PLL_STB] = pll_stable_clear;
	assign clr_w[clk_irq_pkg::F_FAST_STB] = fast_crystal_stable_clear;
	assign clr_w[clk_irq_pkg::F_RC8M] = rc8mhz_stable_clear;
	assign clr_w[clk_irq_pkg::F_SLOW_STB] = slow_crystal_stable_clear;
	assign clr_w[clk_irq_pkg::F_RC40K] = rc40khz_stable_clear;

	// bit 7: stuck flag, also cleared on nmi enable rise
	evt_flag u_flag_fast_stuck
	(
		.mclk(mclk),
		.resetn(resetn),
		.set_i(set_w[clk_irq_pkg::F_FAST_STUCK]),
		.clr_i(clr_w[clk_irq_pkg::F_FAST_STUCK]),
		.flag_q(fast_crystal_stuck_flag)
	);

	// bit 6: pll monitor stuck
	evt_flag u_flag_pll_mon
	(
		.mclk(mclk),
		.resetn(resetn),
		.set_i(set_w[clk_irq_pkg::F_PLL_MON]),
		.clr_i(clr_w[clk_irq_pkg::F_PLL_MON]),
		.flag_q(pll_monitor_flag)
	);

	// bit 5: slow crystal monitor stuck
	evt_flag u_flag_slow_mon
	(
		.mclk(mclk),
		.resetn(resetn),
		.set_i(set_w[clk_irq_pkg::F_SLOW_MON]),
		.clr_i(clr_w[clk_irq_pkg::F_SLOW_MON]),
		.flag_q(slow_crystal_monitor_flag)
	);

	// bit 4: pll stable
	evt_flag u_flag_pll_stb
	(
		.mclk(mclk),
		.resetn(resetn),
		.set_i(set_w[clk_irq_pkg::F_PLL_STB]),
		.clr_i(clr_w[clk_irq_pkg::F_PLL_STB]),
		.flag_q(pll_stable_flag)
	);

	// bit 3: fast crystal stable
	evt_flag u_flag_fast_stb
	(
		.mclk(mclk),
		.resetn(resetn),
		.set_i(set_w[clk_irq_pkg::F_FAST_STB]),
		.clr_i(clr_w[clk_irq_pkg::F_FAST_STB]),
		.flag_q(fast_crystal_stable_flag)
	);

	// bit 2: 8 mhz rc stable
	evt_flag u_flag_rc8m
	(
		.mclk(mclk),
		.resetn(resetn),
		.set_i(set_w[clk_irq_pkg::F_RC8M]),
		.clr_i(clr_w[clk_irq_pkg::F_RC8M]),
		.flag_q(rc8mhz_stable_flag)
	);

	// bit 1: slow crystal stable
	evt_flag u_flag_slow_stb
	(
		.mclk(mclk),
		.resetn(resetn),
		.set_i(set_w[clk_irq_pkg::F_SLOW_STB]),
		.clr_i(clr_w[clk_irq_pkg::F_SLOW_STB]),
		.flag_q(slow_crystal_stable_flag)
	);

	// bit 0: 40 khz rc stable
	evt_flag u_flag_rc40k
	(
		.mclk(mclk),
		.resetn(resetn),
		.set_i(set_w[clk_irq_pkg::F_RC40K]),
		.clr_i(clr_w[clk_irq_pkg::F_RC40K]),
		.flag_q(rc40khz_stable_flag)
	);

	assign flag_w = {fast_crystal_stuck_flag,
		pll_monitor_flag,
		slow_crystal_monitor_flag,
		pll_stable_flag,
		fast_crystal_stable_flag,
		rc8mhz_stable_flag,
		slow_crystal_stable_flag,
		rc40khz_stable_flag};

	// reserved and clear bits are not stored and read as zero
	assign rd_resv_hi = 8'h00;
	assign rd_clear_bits = 8'h00;
	assign rd_resv_15 = 1'b0;
	// enables 10:8 live outside; shown here so software sees one word
	assign rd_ext_en = {rc8mhz_stable_irq_enable,
		slow_crystal_stable_irq_enable,
		rc40khz_stable_irq_enable};

	assign rd_word = {rd_resv_hi, rd_clear_bits, rd_resv_15, en_q,
		rd_ext_en, flag_w};

	// the stuck flag normally routes to nmi, kept in the request too
	assign irq_d = |(flag_w & en_all);

	// read data stands one cycle only; idle bus reads zero
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rdata <= 32'h0000_0000;
		else
			rdata <= (rd & sel) ? rd_word : 32'h0000_0000;
	end

	// flag copy lags the flag state by one cycle
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			flags <= clk_irq_pkg::FLAG_RESET;
		else
			flags <= flag_w;
	end

	// registered request keeps the output glitch free
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			irq <= 1'b0;
		else
			irq <= irq_d;
	end
endmodule : clk_irq_ctrl

//--- logic/clk_irq_pkg.sv
// package for the clock event interrupt register block
// assumes a single 32-bit register on a plain strobe port
package clk_irq_pkg;
	localparam logic [3:0] REG_ADDR = 4'h0;
	localparam int NUM_EVT = 8;
	// flag positions in the low byte
	localparam int F_RC40K = 0;
	localparam int F_SLOW_STB = 1;
	localparam int F_RC8M = 2;
	localparam int F_FAST_STB = 3;
	localparam int F_PLL_STB = 4;
	localparam int F_SLOW_MON = 5;
	localparam int F_PLL_MON = 6;
	localparam int F_FAST_STUCK = 7;
	// clear bits sit at flag position plus this
	localparam int CLR_BASE = 16;
	// enables sit at bits 14:8, same order as flags
	localparam int EN_BASE = 8;
	localparam int EN_LO_WRITABLE = 11;
	localparam int EN_HI_WRITABLE = 14;
	localparam logic [6:0] EN_RESET = 7'h00;
	localparam logic [7:0] FLAG_RESET = 8'h00;
endpackage : clk_irq_pkg

//--- logic/evt_flag.sv
// one sticky event flag with write-one-to-clear
// assumes set and clear are synchronous to mclk
`timescale 1ns/100ps
module evt_flag
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// control
	input wire logic set_i,
	input wire logic clr_i,
	// state
	output logic flag_q
);
	logic flag_d;

	// set wins over a clear in the same cycle, so no event is lost
	assign flag_d = set_i | (flag_q & ~clr_i);

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end
endmodule : evt_flag

//--- sim/clk_irq_ctrl_assertions.sv
// port checks for the clock event interrupt register
// assumes flags and irq lag the strobe by two cycles
`timescale 1ns/100ps
module clk_irq_ctrl_assertions
(
	// bus
	input logic mclk,
	input logic resetn,
	input logic [3:0] addr,
	input logic [31:0] wdata,
	input logic wr,
	input logic rd,
	input logic [31:0] rdata,
	// events and state
	input logic fast_crystal_stuck,
	input logic pll_stuck,
	input logic fast_crystal_monitor_nmi_enable,
	input logic [7:0] flags,
	input logic irq
);
	wire wa = wr && addr == 4'h0;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_stuck_clear: assert property (wa && wdata[23] && !fast_crystal_stuck
		|-> ##2 !flags[7]) else $error("stuck kept");
	a_mon_clear: assert property (wa && wdata[22] && !pll_stuck
		|-> ##2 !flags[6]) else $error("monitor kept");
	a_stuck_set: assert property (fast_crystal_stuck |-> ##2 flags[7])
		else $error("stuck lost");
	a_nmi_clear: assert property ($rose(fast_crystal_monitor_nmi_enable)
		&& !fast_crystal_stuck |-> ##2 !flags[7]) else $error("nmi kept");
	a_enable_read: assert property (wa ##1 rd && addr == 4'h0
		|=> rdata[14:11] == $past(wdata[14:11], 2)) else $error("enables");
	a_resv_zero: assert property (rd |=> rdata[31:15] == 17'h0)
		else $error("upper bits");
	a_irq_idle: assert property (flags == 8'h00 |-> !irq)
		else $error("irq idle");
	a_irq_stuck: assert property (flags[7] |-> irq)
		else $error("irq stuck");
endmodule : clk_irq_ctrl_assertions
bind clk_irq_ctrl clk_irq_ctrl_assertions u_chk(.mclk, .resetn, .addr,
	.wdata, .wr, .rd, .rdata, .fast_crystal_stuck, .pll_stuck,
	.fast_crystal_monitor_nmi_enable, .flags, .irq);

//--- sim/clk_irq_ctrl_tb.sv
// random bench for clk_irq_ctrl
// assumes the checker file is compiled first
`timescale 1ns/100ps
module clk_irq_ctrl_tb;
	logic mclk = 0, resetn = 0, wr = 0, rd = 0, nmi = 0, irq;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, r, w, seed = 32'h0000dd8b;
	logic [7:0] ev = 8'h00, flags, e;
	logic [2:0] xen = 3'h0;
	int n_errors = 0, cmp_count = 0;
	clk_irq_ctrl u_clk_irq_ctrl(.mclk, .resetn, .addr, .wdata, .wr, .rd,
		.rdata, .fast_crystal_stuck(ev[7]), .pll_stuck(ev[6]),
		.slow_crystal_stuck(ev[5]), .pll_stable(ev[4]),
		.fast_crystal_stable(ev[3]), .rc8mhz_stable(ev[2]),
		.slow_crystal_stable(ev[1]), .rc40khz_stable(ev[0]),
		.rc8mhz_stable_irq_enable(xen[2]),
		.slow_crystal_stable_irq_enable(xen[1]),
		.rc40khz_stable_irq_enable(xen[0]),
		.fast_crystal_monitor_nmi_enable(nmi), .flags, .irq);
	initial forever #10 mclk = ~mclk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %0t %h %h", $time, got, exp);
		end
	endtask : chk
	task bus(input logic w_i, r_i, input logic [3:0] a, input logic [31:0] d);
		wr <= w_i;
		rd <= r_i;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
	endtask : bus
	task end_of_test;
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial
	begin
		#20000 n_errors++;
		end_of_test();
	end
	initial
	begin
		repeat (16) @(posedge mclk);
		resetn <= 1;
		@(posedge mclk);
		repeat (40)
		begin
			r = rnd();
			w = r & 32'h00007800;
			bus(1, 0, 4'h0, w | 32'h00ff0000);
			bus(0, 1, 4'h0, 0);
			rd <= 0;
			ev <= 8'hff;
			xen <= r[2:0];
			#1 chk(rdata & 32'hfffff800, w);
			@(posedge mclk);
			ev <= 8'h00;
			// unmapped write must leave every flag alone
			bus(1, 0, 4'h5, 32'h00ff0000);
			bus(1, 0, 4'h0, r & 32'h00ff0000 | w);
			bus(0, 0, 4'h0, 0);
			e = {3'b111, w[12:11], r[2:0]} & ~r[23:16];
			#1 chk(flags, e);
			chk(irq, |(e & {1'b1, w[14:11], r[2:0]}));
			@(posedge mclk);
		end
		ev <= 8'h80;
		bus(0, 0, 4'h0, 0);
		ev <= 8'h00;
		bus(0, 0, 4'h0, 0);
		#1 chk(flags[7], 1);
		chk(irq, 1);
		nmi <= 1;
		repeat (2) @(posedge mclk);
		#1 chk(flags[7], 0);
		end_of_test();
	end
endmodule : clk_irq_ctrl_tb
